/* rtl/ack_timeout_defs.svh */
// Function
// - ack timeout is a configured count in 20 ms units.
// - after a message, wait at most the timeout for the acknowledgment.
// - after a poll, same timeout for a poll response or message.
// - request-to-send to transmission delay is a count of 20 ms units.
// - sent counter counts every transmitted message, retries included.
// - received counter counts only error-free incoming messages.
// - retry counter counts every message retransmission.
// - undelivered counter counts messages never acknowledged.
// - duplicate counter counts messages identical to the previous one.
// - bad-packet counter counts bad packets; no acknowledgment returned for them.
// - completed normal pass records its duration in ms as last normal.
// - completed priority pass records its duration in ms as last priority.
// - maximum pass duration kept separately for normal and priority lists.
// - retry up to configured count, then undeliverable or station inactive.
// - with duplicate detect on, duplicate is acknowledged but not acted on.
//
// Purpose: constants of the ack-timeout supervisor and diagnostics
// Assumes: 100 MHz core clock
// Notes:   register addresses are word indices on the plain port
`ifndef ACK_TIMEOUT_DEFS_SVH
`define ACK_TIMEOUT_DEFS_SVH

`define CLK_PERIOD_NS   10
`define NS_PER_MS       1000000
`define CYC_PER_MS      (`NS_PER_MS / `CLK_PERIOD_NS)
`define UNIT_MS         20

`define A_CTRL          4'h0
`define A_STATUS        4'h1
`define A_MASK          4'h2
`define A_SENT          4'h3
`define A_RECV          4'h4
`define A_RETRY         4'h5
`define A_UNDEL         4'h6
`define A_DUP           4'h7
`define A_BAD           4'h8
`define A_LAST_NORM     4'h9
`define A_LAST_PRI      4'ha
`define A_MAX_NORM      4'hb
`define A_MAX_PRI       4'hc
`define A_STATE         4'hd

`define CTRL_TMO_LSB    0
`define CTRL_RTS_LSB    8
`define CTRL_RETRY_LSB  16
`define CTRL_DUP_BIT    20
`define CTRL_RESET      32'h0000_0000

`define ST_OK_BIT       0
`define ST_UNDEL_BIT    1
`define ST_INACT_BIT    2
`define ST_BAD_BIT      3
`define EV_W            4

`endif

/* rtl/ack_timeout_diag.sv */
// Purpose: master-side reply timeout, retry control and link diagnostics
// Assumes: packet engine supplies one-cycle event pulses, synchronous inputs
// Notes:   all times are counted in cycles of core_clk
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ack_timeout_defs.svh"

module ack_timeout_diag #(
    parameter int CYC_PER_MS = `CYC_PER_MS,
    parameter int CNT_W      = 16
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // register port
    input  wire logic [3:0]       reg_addr,
    input  wire logic [31:0]      reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [31:0]      reg_rdata,
    output logic                  irq,
    // transmit side
    input  wire logic             tx_req,
    input  wire logic             tx_is_poll,
    input  wire logic             tx_done,
    output logic                  rts,
    output logic                  tx_go,
    output logic                  tx_busy,
    // reply side
    input  wire logic             ack_rx,
    input  wire logic             reply_rx,
    input  wire logic             rx_good,
    input  wire logic             rx_bad,
    input  wire logic             rx_dup,
    output logic                  ack_tx,
    output logic                  rx_accept,
    // outcome pulses
    output logic                  xfer_ok,
    output logic                  undeliverable,
    output logic                  station_inactive,
    // poll list passes
    input  wire logic             norm_start,
    input  wire logic             norm_end,
    input  wire logic             pri_start,
    input  wire logic             pri_end
);

    localparam int UNIT_CYC = `UNIT_MS * CYC_PER_MS;

    if (CYC_PER_MS < 1 || CNT_W < 1 || CNT_W > 32 || UNIT_CYC < 2)
    begin : g_bad_param
        $error("ack_timeout_diag: unsupported parameter values");
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
        return (&v) ? v : v + CNT_W'(1);
    endfunction : sat_inc

    // configuration
    logic [31:0]               ctrl_q;
    logic [`EV_W-1:0]          status_q;
    logic [`EV_W-1:0]          mask_q;
    logic [7:0]                cfg_tmo;
    logic [7:0]                cfg_rts;
    logic [3:0]                cfg_retries;
    logic                      cfg_dup;

    assign cfg_tmo     = ctrl_q[`CTRL_TMO_LSB +: 8];
    assign cfg_rts     = ctrl_q[`CTRL_RTS_LSB +: 8];
    assign cfg_retries = ctrl_q[`CTRL_RETRY_LSB +: 4];
    assign cfg_dup     = ctrl_q[`CTRL_DUP_BIT];

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            ctrl_q <= `CTRL_RESET;
        else if (reg_wr && reg_addr == `A_CTRL)
            ctrl_q <= reg_wdata;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            mask_q <= '0;
        else if (reg_wr && reg_addr == `A_MASK)
            mask_q <= reg_wdata[`EV_W-1:0];
    end

    // link state machine
    ack_timeout_pkg::link_state_t state_q;
    ack_timeout_pkg::link_state_t state_d;
    logic                      poll_q;
    logic [3:0]                tries_q;
    logic [31:0]               pre_q;
    logic [7:0]                units_q;
    logic                      unit_tick;
    logic                      got_reply;
    logic                      expired;
    logic                      give_up;
    logic                      retry_now;

    assign unit_tick = (pre_q == 32'(UNIT_CYC - 1));
    assign got_reply = poll_q ? reply_rx : ack_rx;
    // timeout of N expires at the Nth unit boundary after the last character
    assign expired   = (state_q == ack_timeout_pkg::ST_WAIT) && !got_reply && unit_tick
                       && (units_q + 8'h01 >= cfg_tmo);
    assign give_up   = expired && (tries_q >= cfg_retries);
    assign retry_now = expired && (tries_q < cfg_retries);

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ack_timeout_pkg::ST_IDLE:
                if (tx_req) state_d = ack_timeout_pkg::ST_RTS;
            ack_timeout_pkg::ST_RTS:
                if (units_q >= cfg_rts) state_d = ack_timeout_pkg::ST_SEND;
            ack_timeout_pkg::ST_SEND:
                if (tx_done) state_d = ack_timeout_pkg::ST_WAIT;
            ack_timeout_pkg::ST_WAIT:
            begin
                if (got_reply || give_up)
                    state_d = ack_timeout_pkg::ST_IDLE;
                else if (retry_now)
                    state_d = ack_timeout_pkg::ST_RTS;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_q <= ack_timeout_pkg::ST_IDLE;
        else
            state_q <= state_d;
    end

    // unit timer restarts on every state change, so waits are whole units
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pre_q   <= '0;
            units_q <= '0;
        end
        else if (state_d != state_q)
        begin
            pre_q   <= '0;
            units_q <= '0;
        end
        else if (unit_tick)
        begin
            pre_q   <= '0;
            units_q <= (&units_q) ? units_q : units_q + 8'h01;
        end
        else
            pre_q <= pre_q + 32'h1;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            poll_q  <= 1'b0;
            tries_q <= '0;
        end
        else if (state_q == ack_timeout_pkg::ST_IDLE && tx_req)
        begin
            poll_q  <= tx_is_poll;
            tries_q <= '0;
        end
        else if (retry_now)
            tries_q <= tries_q + 4'h1;
    end

    // transmit handshake outputs
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rts     <= 1'b0;
            tx_go   <= 1'b0;
            tx_busy <= 1'b0;
        end
        else
        begin
            rts     <= (state_d == ack_timeout_pkg::ST_RTS)
                       || (state_d == ack_timeout_pkg::ST_SEND);
            tx_go   <= (state_q == ack_timeout_pkg::ST_RTS)
                       && (state_d == ack_timeout_pkg::ST_SEND);
            tx_busy <= (state_d != ack_timeout_pkg::ST_IDLE);
        end
    end

    // outcome pulses
    logic                      msg_fail;
    logic                      poll_fail;
    logic                      ok_now;

    assign ok_now    = (state_q == ack_timeout_pkg::ST_WAIT) && got_reply;
    assign msg_fail  = give_up && !poll_q;
    assign poll_fail = give_up && poll_q;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            xfer_ok          <= 1'b0;
            undeliverable    <= 1'b0;
            station_inactive <= 1'b0;
        end
        else
        begin
            xfer_ok          <= ok_now;
            undeliverable    <= msg_fail;
            station_inactive <= poll_fail;
        end
    end

    // receive side: bad packets get no acknowledgment
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_tx    <= 1'b0;
            rx_accept <= 1'b0;
        end
        else
        begin
            ack_tx    <= rx_good && !rx_bad;
            rx_accept <= rx_good && !rx_bad && !(cfg_dup && rx_dup);
        end
    end

    // diagnostic counters
    logic [CNT_W-1:0]          cnt_q [6];
    logic [5:0]                cnt_inc;

    assign cnt_inc[ack_timeout_pkg::C_SENT]  = (state_q == ack_timeout_pkg::ST_SEND)
                                               && tx_done && !poll_q;
    assign cnt_inc[ack_timeout_pkg::C_RECV]  = rx_good && !rx_bad;
    assign cnt_inc[ack_timeout_pkg::C_RETRY] = retry_now && !poll_q;
    assign cnt_inc[ack_timeout_pkg::C_UNDEL] = msg_fail;
    assign cnt_inc[ack_timeout_pkg::C_DUP]   = rx_good && !rx_bad && rx_dup;
    assign cnt_inc[ack_timeout_pkg::C_BAD]   = rx_bad;

    for (genvar i = 0; i < 6; i++)
    begin : g_cnt
        always_ff @(posedge core_clk or negedge rst_n)
        begin
            if (!rst_n)
                cnt_q[i] <= '0;
            else if (cnt_inc[i])
                cnt_q[i] <= sat_inc(cnt_q[i]);
        end
    end

    // poll list pass timing, index 0 normal, 1 priority
    logic [31:0]               ms_pre_q;
    logic                      ms_tick;
    logic [1:0]                pass_start;
    logic [1:0]                pass_end;
    logic [1:0]                run_q;
    logic [CNT_W-1:0]          run_ms_q  [2];
    logic [CNT_W-1:0]          last_ms_q [2];
    logic [CNT_W-1:0]          max_ms_q  [2];

    assign ms_tick    = (ms_pre_q == 32'(CYC_PER_MS - 1));
    assign pass_start = {pri_start, norm_start};
    assign pass_end   = {pri_end, norm_end};

    // free-running ms base; a pass is timed to within one ms
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            ms_pre_q <= '0;
        else if (ms_tick)
            ms_pre_q <= '0;
        else
            ms_pre_q <= ms_pre_q + 32'h1;
    end

    for (genvar p = 0; p < 2; p++)
    begin : g_pass
        logic [CNT_W-1:0] dur;
        assign dur = (ms_tick && run_q[p]) ? sat_inc(run_ms_q[p]) : run_ms_q[p];

        always_ff @(posedge core_clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                run_q[p]     <= 1'b0;
                run_ms_q[p]  <= '0;
                last_ms_q[p] <= '0;
                max_ms_q[p]  <= '0;
            end
            else if (pass_end[p] && run_q[p])
            begin
                last_ms_q[p] <= dur;
                if (dur > max_ms_q[p])
                    max_ms_q[p] <= dur;
                run_q[p]     <= pass_start[p];
                run_ms_q[p]  <= '0;
            end
            else if (pass_start[p])
            begin
                run_q[p]    <= 1'b1;
                run_ms_q[p] <= '0;
            end
            else
                run_ms_q[p] <= dur;
        end
    end

    // sticky events, write one to clear; a new event wins over the clear
    logic [`EV_W-1:0]          ev;
    logic [`EV_W-1:0]          clr;

    assign ev[`ST_OK_BIT]    = ok_now;
    assign ev[`ST_UNDEL_BIT] = msg_fail;
    assign ev[`ST_INACT_BIT] = poll_fail;
    assign ev[`ST_BAD_BIT]   = rx_bad;
    assign clr = (reg_wr && reg_addr == `A_STATUS) ? reg_wdata[`EV_W-1:0] : '0;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            status_q <= '0;
        else
            status_q <= (status_q & ~clr) | ev;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= |(((status_q & ~clr) | ev) & mask_q);
    end

    // register read, data one cycle after the strobe
    function automatic logic [31:0] rd_mux(input logic [3:0] a);
        unique case (a)
            `A_CTRL:      return ctrl_q;
            `A_STATUS:    return 32'(status_q);
            `A_MASK:      return 32'(mask_q);
            `A_SENT:      return 32'(cnt_q[ack_timeout_pkg::C_SENT]);
            `A_RECV:      return 32'(cnt_q[ack_timeout_pkg::C_RECV]);
            `A_RETRY:     return 32'(cnt_q[ack_timeout_pkg::C_RETRY]);
            `A_UNDEL:     return 32'(cnt_q[ack_timeout_pkg::C_UNDEL]);
            `A_DUP:       return 32'(cnt_q[ack_timeout_pkg::C_DUP]);
            `A_BAD:       return 32'(cnt_q[ack_timeout_pkg::C_BAD]);
            `A_LAST_NORM: return 32'(last_ms_q[0]);
            `A_LAST_PRI:  return 32'(last_ms_q[1]);
            `A_MAX_NORM:  return 32'(max_ms_q[0]);
            `A_MAX_PRI:   return 32'(max_ms_q[1]);
            `A_STATE:     return {24'h0, tries_q, 1'b0, poll_q, 2'(state_q)};
            default:      return 32'h0000_0000;
        endcase
    endfunction : rd_mux

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= '0;
        else if (reg_rd)
            reg_rdata <= rd_mux(reg_addr);
        else
            reg_rdata <= '0;
    end

    // checks
    a_no_ack_bad: assert property (rx_bad |=> !ack_tx)
        else $error("ack sent for a bad packet");
    a_dup_not_act: assert property (rx_good && !rx_bad && rx_dup && cfg_dup
        |=> ack_tx && !rx_accept)
        else $error("duplicate acted upon or not acknowledged");
    a_sent_count: assert property ((state_q == ack_timeout_pkg::ST_SEND) && tx_done && !poll_q
        && !(&cnt_q[0]) |=> cnt_q[0] == $past(cnt_q[0]) + CNT_W'(1))
        else $error("sent counter missed a message");
    a_retry_count: assert property (retry_now && !poll_q && !(&cnt_q[2])
        |=> cnt_q[2] == $past(cnt_q[2]) + CNT_W'(1))
        else $error("retry counter missed a retry");
    a_counter_sat: assert property ((&cnt_q[5]) |=> (&cnt_q[5]))
        else $error("bad counter wrapped");
    a_expire_bound: assert property (expired |-> units_q + 8'h01 >= cfg_tmo
        && pre_q == 32'(UNIT_CYC - 1))
        else $error("timeout fired before its unit count");
    a_giveup_pulse: assert property (give_up && !poll_q
        |=> undeliverable && !station_inactive ##1 !undeliverable)
        else $error("undeliverable pulse wrong");
    a_retry_limit: assert property (state_q == ack_timeout_pkg::ST_WAIT
        |-> tries_q <= cfg_retries || $changed(cfg_retries)
        || $past(state_q) == ack_timeout_pkg::ST_WAIT)
        else $error("retries above limit");
    a_last_norm: assert property (norm_end && run_q[0] && !ms_tick
        |=> last_ms_q[0] == $past(run_ms_q[0]))
        else $error("normal pass time not recorded");
    a_max_pri: assert property (pri_end && run_q[1]
        |=> max_ms_q[1] >= last_ms_q[1])
        else $error("priority max below last");

endmodule : ack_timeout_diag
`default_nettype wire

/* rtl/ack_timeout_pkg.sv */
// Purpose: types of the ack-timeout supervisor
// Assumes: nothing
// Notes:   constants live in ack_timeout_defs.svh
package ack_timeout_pkg;

    typedef enum logic [1:0]
    {
        ST_IDLE,
        ST_RTS,
        ST_SEND,
        ST_WAIT
    } link_state_t;

    typedef enum logic [2:0]
    {
        C_SENT,
        C_RECV,
        C_RETRY,
        C_UNDEL,
        C_DUP,
        C_BAD
    } counter_t;

endpackage : ack_timeout_pkg

/* testbench/slave_model.sv */
// Purpose: slave station and packet engine stand-in on the link side
// Assumes: one packet per tx_go, eight cycles of characters
// Notes:   answers late, promptly or never, as the bench commands
`timescale 1ns/1ps
`default_nettype none
module slave_model (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // bench control
    input  wire logic        is_poll,
    input  wire logic        answer,
    input  wire logic [15:0] reply_dly,
    // link side
    input  wire logic        tx_go,
    output logic             tx_done,
    output logic             ack_rx,
    output logic             reply_rx
);
    initial
    begin
        tx_done  = 1'b0;
        ack_rx   = 1'b0;
        reply_rx = 1'b0;
    end

    always
    begin
        @(posedge core_clk);
        if (rst_n === 1'b1 && tx_go === 1'b1)
        begin
            repeat (8) @(posedge core_clk);
            tx_done <= 1'b1;
            @(posedge core_clk);
            tx_done <= 1'b0;
            if (answer)
            begin
                repeat (reply_dly) @(posedge core_clk);
                ack_rx   <= ~is_poll;
                reply_rx <= is_poll;
                @(posedge core_clk);
                ack_rx   <= 1'b0;
                reply_rx <= 1'b0;
            end
        end
    end
endmodule : slave_model
`default_nettype wire

/* testbench/tb.sv */
// Purpose: self-checking bench of the reply-timeout supervisor
// Assumes: 5 cycles per ms, so one 20 ms unit is 100 cycles
// Notes:   4-bit counters so saturation is reached quickly
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int UNIT = 100;
    logic        core_clk, rst_n, reg_wr, reg_rd, irq;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, v, r;
    logic        tx_req, tx_is_poll, tx_done, rts, tx_go, tx_busy;
    logic        ack_rx, reply_rx, rx_good, rx_bad, rx_dup, ack_tx, rx_accept;
    logic        xfer_ok, undeliverable, station_inactive;
    logic        norm_start, norm_end, pri_start, pri_end, answer;
    logic [15:0] reply_dly;
    int          failures, tests_run, seed;
    int          mdl[16];

    ack_timeout_diag #(.CYC_PER_MS(5), .CNT_W(4)) u_dut (
        .core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
        .tx_req, .tx_is_poll, .tx_done, .rts, .tx_go, .tx_busy, .ack_rx, .reply_rx,
        .rx_good, .rx_bad, .rx_dup, .ack_tx, .rx_accept, .xfer_ok, .undeliverable,
        .station_inactive, .norm_start, .norm_end, .pri_start, .pri_end);

    slave_model u_slave (.core_clk, .rst_n, .is_poll(tx_is_poll), .answer, .reply_dly,
        .tx_go, .tx_done, .ack_rx, .reply_rx);

    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            failures++;
            $display("mismatch %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk

    task automatic chk_in(input string nm, input int lo, input int hi, input logic [31:0] g);
        tests_run++;
        if (^g === 1'bx || g < lo || g > hi)
        begin
            failures++;
            $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask : chk_in

    function automatic void bump(input int a);
        if (mdl[a] < 15)
            mdl[a]++;
    endfunction : bump

    function automatic logic sig(input int k);
        case (k)
            0: return xfer_ok;
            1: return undeliverable;
            2: return station_inactive;
            3: return tx_go;
            default: return tx_done;
        endcase
    endfunction : sig

    task automatic wait_for(input int k, input int lim, output int c);
        c = 0;
        while (sig(k) !== 1'b1)
        begin
            @(posedge core_clk);
            #1;
            c++;
            if (c > lim)
            begin
                failures++;
                $display("mismatch wait %0d expected 1 seen 0", k);
                final_report;
            end
        end
    endtask : wait_for

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    // scan registers are checked on their own since their values carry slack
    task automatic chk_all;
        for (int a = 0; a < 16; a++)
        begin
            if (a < 9 || a > 12)
            begin
                rd(a[3:0], v);
                chk($sformatf("reg %0d", a), mdl[a], v);
            end
        end
        chk("irq", (mdl[1] & mdl[2]) != 0, irq);
    endtask : chk_all

    task automatic pulse(input int k);
        @(posedge core_clk);
        case (k)
            0: norm_start <= 1'b1;
            1: norm_end <= 1'b1;
            2: pri_start <= 1'b1;
            default: pri_end <= 1'b1;
        endcase
        @(posedge core_clk);
        {norm_start, norm_end, pri_start, pri_end} <= 4'h0;
        #1;
    endtask : pulse

    task automatic send(input logic poll, input logic ans, input int dly, input int lo,
                        input int hi);
        int c;
        int att;
        att = ans ? 1 : ((mdl[0] >> 16) & 15) + 1;
        answer    = ans;
        reply_dly = dly[15:0];
        @(posedge core_clk);
        tx_is_poll <= poll;
        tx_req     <= 1'b1;
        @(posedge core_clk);
        tx_req <= 1'b0;
        #1;
        wait_for(3, 30000, c);
        c = c - ((mdl[0] >> 8) & 255) * UNIT;
        chk_in("send delay", 0, 4, c);
        chk("rts", 1'b1, rts);
        wait_for(4, 100, c);
        wait_for(ans ? 0 : (poll ? 2 : 1), 2000, c);
        chk_in("outcome delay", lo, hi, c);
        #10;
        chk("busy", 1'b0, tx_busy);
        if (!poll)
            repeat (att) bump(3);
        if (!poll && !ans)
        begin
            repeat (att - 1) bump(5);
            bump(6);
        end
        mdl[1] |= ans ? 1 : (poll ? 4 : 2);
    endtask : send

    task automatic rx(input logic good, input logic dup);
        int en;
        en = (mdl[0] >> 20) & 1;
        @(posedge core_clk);
        rx_good <= good;
        rx_bad  <= ~good;
        rx_dup  <= dup;
        @(posedge core_clk);
        {rx_good, rx_bad, rx_dup} <= 3'h0;
        #1;
        chk("ack_tx", good, ack_tx);
        chk("rx_accept", good && !(dup && en), rx_accept);
        if (good)
            bump(4);
        if (dup)
            bump(7);
        if (!good)
        begin
            bump(8);
            mdl[1] |= 8;
        end
    endtask : rx

    initial
    begin
        seed = 32'h4dc0;
        {rst_n, reg_wr, reg_rd, tx_req, tx_is_poll, rx_good, rx_bad, rx_dup} = 8'h00;
        {norm_start, norm_end, pri_start, pri_end, answer} = 5'h00;
        reg_addr  = 4'h0;
        reg_wdata = 32'h0000_0000;
        reply_dly = 16'h0000;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        chk_all;
        wr(4'hf, 32'hffff_ffff);
        wr(4'h3, 32'h0000_0005);
        mdl[0] = 32'h0011_0002;
        wr(4'h0, mdl[0]);
        send(1'b0, 1'b1, 50, 50, 56);
        send(1'b0, 1'b0, 0, 400, 440);
        mdl[0] = 32'h0000_0002;
        wr(4'h0, mdl[0]);
        send(1'b1, 1'b0, 0, 199, 204);
        send(1'b1, 1'b1, 190, 190, 196);
        mdl[0] = 32'h0010_0102;
        wr(4'h0, mdl[0]);
        send(1'b0, 1'b1, 10, 10, 16);
        chk_all;
        for (int i = 0; i < 30; i++)
        begin
            if (i == 15)
            begin
                mdl[0] ^= 32'h0010_0000;
                wr(4'h0, mdl[0]);
            end
            r = $random(seed);
            rx(r[0] | r[2], r[0] & r[1]);
        end
        chk_all;
        mdl[2] = 2;
        wr(4'h2, 32'h0000_0002);
        chk_all;
        mdl[1] &= ~2;
        wr(4'h1, 32'h0000_0002);
        chk_all;
        mdl[2] = 15;
        wr(4'h2, 32'h0000_000f);
        chk_all;
        // two passes per list: the short one must not lower the maximum
        for (int l = 0; l < 2; l++)
        begin
            for (int p = 0; p < 2; p++)
            begin
                pulse(2 * l);
                repeat (p ? 15 : 35) @(posedge core_clk);
                pulse(2 * l + 1);
                rd(4'h9 + l[3:0], v);
                chk_in("last scan", p ? 2 : 6, p ? 4 : 8, v);
            end
            rd(4'hb + l[3:0], v);
            chk_in("max scan", 6, 8, v);
        end
        final_report;
    end
endmodule : tb
`default_nettype wire
